// File: hdl/sgd_dma.v
// Purpose: two-channel scatter/gather dma engine with linked descriptors
// Assumes: one memory master port per channel, external bus arbitration
// Notes:   register port answers every read one cycle later
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "sgd_regs.vh"

// ****************
// one dma channel with its own fifo
// ****************
module sgd_chan #(
   parameter TO_HOST = 1
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // control from register file
   input wire en,
   input wire soft_rst,
   input wire [31:0] first_ptr,
   input wire unhold,
   // status to register file
   output reg [31:0] cur_ptr_r,
   output reg [8:0] lvl_r,
   output reg idle_r,
   output reg done_r,
   output reg err_r,
   output reg [15:0] count_r,
   output reg desc_evt_r,
   // memory master
   output reg cmd_valid_r,
   output reg cmd_we_r,
   output reg [31:0] cmd_addr_r,
   output reg [4:0] cmd_len_r,
   input wire cmd_ready,
   input wire rvalid,
   input wire [31:0] rdata,
   output reg wvalid_r,
   output reg [31:0] wdata_r,
   input wire wready,
   input wire abort,
   // converter stream in
   input wire cnv_valid,
   input wire [31:0] cnv_data,
   output reg cnv_ready_r,
   // dac stream out
   output reg dac_valid_r,
   output reg [31:0] dac_data_r,
   input wire dac_ready
);

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_FREQ = 4'h1;
   localparam [3:0] ST_FDAT = 4'h2;
   localparam [3:0] ST_XREQ = 4'h3;
   localparam [3:0] ST_XDAT = 4'h4;
   localparam [3:0] ST_SREQ = 4'h5;
   localparam [3:0] ST_SDAT = 4'h6;
   localparam [3:0] ST_HOLD = 4'h7;
   localparam [3:0] ST_ERR = 4'h8;

   reg [3:0] st_r;
   reg [31:0] d0_r;
   reg [31:0] dbuf_r;
   reg [31:0] dnext_r;
   reg [1:0] fidx_r;
   reg [4:0] bl_r;
   reg [31:0] fifo_mem [0:255];
   reg [7:0] wp_r;
   reg [7:0] rp_r;
   wire push;
   wire pop;
   wire wr_pop;
   wire dac_pop;
   wire [31:0] push_data;
   wire [15:0] rem;
   wire [15:0] blen16;
   wire [8:0] avail;

   // fifo sides swap with direction [RULE_08]
   assign wr_pop = (TO_HOST != 0) && (st_r == ST_XDAT) && !wvalid_r &&
                   (bl_r != 5'h00);
   assign dac_pop = (TO_HOST == 0) && (lvl_r != 9'h000) &&
                    (!dac_valid_r || dac_ready);
   assign push = (TO_HOST != 0) ? (cnv_valid && cnv_ready_r) :
                 (st_r == ST_XDAT && rvalid);
   assign pop = (TO_HOST != 0) ? wr_pop : dac_pop;
   assign push_data = (TO_HOST != 0) ? cnv_data : rdata;

   // full sixteen-word bursts unless the tail is shorter [RULE_07]
   assign rem = d0_r[31:16] - count_r;
   assign blen16 = (rem > `SGD_BURST) ? `SGD_BURST : rem;
   assign avail = (TO_HOST != 0) ? lvl_r : (`SGD_FIFO_DEPTH - lvl_r);

   // fifo storage, no reset needed on the array
   always @(posedge ref_clk)
   begin
      if (push)
         fifo_mem[wp_r] <= push_data;
   end

   // fifo pointers and level; absorbs bus latency [RULE_09]
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_r <= 8'h00;
         rp_r <= 8'h00;
         lvl_r <= 9'h000;
         cnv_ready_r <= 1'b0;
      end
      else if (soft_rst)
      begin
         wp_r <= 8'h00;
         rp_r <= 8'h00;
         lvl_r <= 9'h000;
         cnv_ready_r <= 1'b0;
      end
      else
      begin
         if (push)
            wp_r <= wp_r + 8'h01;
         if (pop)
            rp_r <= rp_r + 8'h01;
         if (push && !pop)
            lvl_r <= lvl_r + 9'h001;
         else if (pop && !push)
            lvl_r <= lvl_r - 9'h001;
         // margin of two covers the registered ready
         cnv_ready_r <= (TO_HOST != 0) && (lvl_r < `SGD_FIFO_HIWAT);
      end
   end

   // dac output stage keeps the stream port registered
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dac_valid_r <= 1'b0;
         dac_data_r <= 32'h0000_0000;
      end
      else if (soft_rst)
         dac_valid_r <= 1'b0;
      else if (dac_pop)
      begin
         dac_valid_r <= 1'b1;
         dac_data_r <= fifo_mem[rp_r];
      end
      else if (dac_ready)
         dac_valid_r <= 1'b0;
   end

   // descriptor walker
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= ST_IDLE;
         cur_ptr_r <= `SGD_PTR_RESET;
         d0_r <= 32'h0000_0000;
         dbuf_r <= 32'h0000_0000;
         dnext_r <= 32'h0000_0000;
         fidx_r <= 2'h0;
         bl_r <= 5'h00;
         count_r <= 16'h0000;
         idle_r <= 1'b1;
         done_r <= 1'b0;
         err_r <= 1'b0;
         desc_evt_r <= 1'b0;
         cmd_valid_r <= 1'b0;
         cmd_we_r <= 1'b0;
         cmd_addr_r <= 32'h0000_0000;
         cmd_len_r <= 5'h00;
         wvalid_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
      end
      else if (soft_rst)
      begin
         // reset stops the channel; the pointer stays for inspection
         st_r <= ST_IDLE;
         idle_r <= 1'b1;
         done_r <= 1'b0;
         err_r <= 1'b0;
         desc_evt_r <= 1'b0;
         cmd_valid_r <= 1'b0;
         wvalid_r <= 1'b0;
         bl_r <= 5'h00;
      end
      else
      begin
         desc_evt_r <= 1'b0;
         idle_r <= (st_r == ST_IDLE);
         if (abort && st_r != ST_IDLE && st_r != ST_HOLD && st_r != ST_ERR)
         begin
            // fatal; cur_ptr_r still names the culprit [RULE_02]
            st_r <= ST_ERR;
            err_r <= 1'b1;
            cmd_valid_r <= 1'b0;
            wvalid_r <= 1'b0;
         end
         else
         begin
            case (st_r)
               ST_IDLE:
                  if (en)
                  begin
                     cur_ptr_r <= first_ptr; // [RULE_12] [RULE_21]
                     done_r <= 1'b0;
                     st_r <= ST_FREQ;
                  end
               ST_FREQ:
                  // commands are only issued while enabled [RULE_21]
                  if (cmd_valid_r && cmd_ready)
                  begin
                     cmd_valid_r <= 1'b0;
                     fidx_r <= 2'h0;
                     st_r <= ST_FDAT;
                  end
                  else if (!cmd_valid_r && en)
                  begin
                     cmd_valid_r <= 1'b1;
                     cmd_we_r <= 1'b0;
                     cmd_addr_r <= cur_ptr_r; // [RULE_11]
                     cmd_len_r <= `SGD_DESC_WORDS;
                  end
               ST_FDAT:
                  if (rvalid)
                  begin
                     // size/control, buffer, next pointer [RULE_10]
                     fidx_r <= fidx_r + 2'h1;
                     if (fidx_r == 2'h0)
                        d0_r <= rdata;
                     else if (fidx_r == 2'h1)
                        dbuf_r <= rdata;
                     else
                     begin
                        dnext_r <= rdata;
                        count_r <= 16'h0000;
                        st_r <= ST_XREQ;
                     end
                  end
               ST_XREQ:
                  if (cmd_valid_r && cmd_ready)
                  begin
                     cmd_valid_r <= 1'b0;
                     st_r <= ST_XDAT;
                  end
                  else if (!cmd_valid_r && rem == 16'h0000)
                     st_r <= ST_SREQ; // null descriptor moves no data [RULE_17]
                  else if (!cmd_valid_r && en &&
                           {7'h00, avail} >= blen16)
                  begin
                     cmd_valid_r <= 1'b1;
                     cmd_we_r <= (TO_HOST != 0); // [RULE_08]
                     cmd_addr_r <= dbuf_r + {14'h0000, count_r, 2'h0};
                     cmd_len_r <= blen16[4:0]; // [RULE_07]
                     bl_r <= blen16[4:0];
                  end
               ST_XDAT:
                  if (TO_HOST != 0)
                  begin
                     if (wvalid_r && wready)
                     begin
                        wvalid_r <= 1'b0;
                        count_r <= count_r + 16'h0001;
                        bl_r <= bl_r - 5'h01;
                        if (bl_r == 5'h01)
                           st_r <= ST_XREQ;
                     end
                     else if (wr_pop)
                     begin
                        wvalid_r <= 1'b1;
                        wdata_r <= fifo_mem[rp_r];
                     end
                  end
                  else if (rvalid)
                  begin
                     count_r <= count_r + 16'h0001;
                     bl_r <= bl_r - 5'h01;
                     if (bl_r == 5'h01)
                        st_r <= ST_XREQ;
                  end
               ST_SREQ:
                  if (cmd_valid_r && cmd_ready)
                  begin
                     cmd_valid_r <= 1'b0;
                     wvalid_r <= 1'b1;
                     // used count and done bit into word 3 [RULE_14]
                     wdata_r <= {count_r, 15'h0000, 1'b1};
                     st_r <= ST_SDAT;
                  end
                  else if (!cmd_valid_r && en)
                  begin
                     cmd_valid_r <= 1'b1;
                     cmd_we_r <= 1'b1;
                     cmd_addr_r <= cur_ptr_r + `SGD_DESC_STAT_OFS;
                     cmd_len_r <= 5'h01;
                  end
               ST_SDAT:
                  if (wvalid_r && wready)
                  begin
                     wvalid_r <= 1'b0;
                     desc_evt_r <= d0_r[`SGD_D0_IRQ]; // [RULE_15]
                     if (d0_r[`SGD_D0_LIST_END])
                     begin
                        done_r <= 1'b1; // [RULE_13] [RULE_22]
                        st_r <= ST_HOLD;
                     end
                     else
                     begin
                        // appended chains are just followed [RULE_18]
                        cur_ptr_r <= dnext_r; // [RULE_13] [RULE_24]
                        st_r <= ST_FREQ;
                     end
                  end
               ST_HOLD:
                  if (unhold)
                  begin
                     // refetch the same descriptor [RULE_03] [RULE_20]
                     done_r <= 1'b0;
                     st_r <= ST_FREQ;
                  end
               default:
                  st_r <= ST_ERR; // leave only by channel reset
            endcase
         end
      end
   end

endmodule // sgd_chan

// ****************
// top: register file and two channels
// ****************
module sgd_dma (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_r,
   // converter channel memory master
   output wire cv_cmd_valid,
   output wire cv_cmd_we,
   output wire [31:0] cv_cmd_addr,
   output wire [4:0] cv_cmd_len,
   input wire cv_cmd_ready,
   input wire cv_rvalid,
   input wire [31:0] cv_rdata,
   output wire cv_wvalid,
   output wire [31:0] cv_wdata,
   input wire cv_wready,
   input wire cv_abort,
   // output channel memory master
   output wire ou_cmd_valid,
   output wire ou_cmd_we,
   output wire [31:0] ou_cmd_addr,
   output wire [4:0] ou_cmd_len,
   input wire ou_cmd_ready,
   input wire ou_rvalid,
   input wire [31:0] ou_rdata,
   output wire ou_wvalid,
   output wire [31:0] ou_wdata,
   input wire ou_wready,
   input wire ou_abort,
   // converter sample stream
   input wire cnv_valid,
   input wire [31:0] cnv_data,
   output wire cnv_ready,
   // dac sample stream
   output wire dac_valid,
   output wire [31:0] dac_data,
   input wire dac_ready,
   // descriptor completion events
   output wire cv_desc_evt,
   output wire ou_desc_evt
);

   reg [1:0] en_r;
   reg [1:0] srst_r;
   reg [1:0] unhold_r;
   reg [31:0] first_cv_r;
   reg [31:0] first_ou_r;
   wire [31:0] cur_cv;
   wire [31:0] cur_ou;
   wire [8:0] lvl_cv;
   wire [8:0] lvl_ou;
   wire [1:0] idle;
   wire [1:0] done;
   wire [1:0] err;
   wire [15:0] cnt_cv;
   wire [15:0] cnt_ou;

   // register writes; reset and unhold are one-cycle pulses
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_r <= 2'h0;
         srst_r <= 2'h0;
         unhold_r <= 2'h0;
         first_cv_r <= `SGD_PTR_RESET;
         first_ou_r <= `SGD_PTR_RESET;
      end
      else
      begin
         srst_r <= 2'h0;
         unhold_r <= 2'h0;
         if (reg_wr)
         begin
            if (reg_addr == `SGD_CSR_CNV)
            begin
               en_r[0] <= reg_wdata[`SGD_CSR_EN];
               srst_r[0] <= reg_wdata[`SGD_CSR_RST];
            end
            else if (reg_addr == `SGD_CSR_OUT)
            begin
               en_r[1] <= reg_wdata[`SGD_CSR_EN];
               srst_r[1] <= reg_wdata[`SGD_CSR_RST];
            end
            else if (reg_addr == `SGD_FIRST_CNV)
               first_cv_r <= reg_wdata;
            else if (reg_addr == `SGD_FIRST_OUT)
               first_ou_r <= reg_wdata;
            else if (reg_addr == `SGD_CUR_CNV)
               unhold_r[0] <= 1'b1; // data ignored [RULE_23]
            else if (reg_addr == `SGD_CUR_OUT)
               unhold_r[1] <= 1'b1; // data ignored [RULE_23]
         end
      end
   end

   // register reads; data stand one cycle after the strobe
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_r <= 32'h0000_0000;
      else if (!reg_rd)
         reg_rdata_r <= 32'h0000_0000;
      else if (reg_addr == `SGD_CSR_CNV)
         reg_rdata_r <= {cnt_cv, 5'h00, err[0], done[0], idle[0],
                         6'h00, 1'b0, en_r[0]};
      else if (reg_addr == `SGD_CSR_OUT)
         reg_rdata_r <= {cnt_ou, 5'h00, err[1], done[1], idle[1],
                         6'h00, 1'b0, en_r[1]};
      else if (reg_addr == `SGD_FIRST_CNV)
         reg_rdata_r <= first_cv_r;
      else if (reg_addr == `SGD_FIRST_OUT)
         reg_rdata_r <= first_ou_r;
      else if (reg_addr == `SGD_CUR_CNV)
         reg_rdata_r <= cur_cv; // [RULE_01]
      else if (reg_addr == `SGD_CUR_OUT)
         reg_rdata_r <= cur_ou; // [RULE_01]
      else if (reg_addr == `SGD_FILL)
         // levels move while read, so only approximate [RULE_04] [RULE_05]
         reg_rdata_r <= {7'h00, lvl_ou, 7'h00, lvl_cv};
      else
         reg_rdata_r <= 32'h0000_0000;
   end

   // converter channel: fifo filled by samples, drained to host
   sgd_chan #(.TO_HOST(1)) u_cv (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .en(en_r[0]),
      .soft_rst(srst_r[0]),
      .first_ptr(first_cv_r),
      .unhold(unhold_r[0]),
      .cur_ptr_r(cur_cv),
      .lvl_r(lvl_cv),
      .idle_r(idle[0]),
      .done_r(done[0]),
      .err_r(err[0]),
      .count_r(cnt_cv),
      .desc_evt_r(cv_desc_evt),
      .cmd_valid_r(cv_cmd_valid),
      .cmd_we_r(cv_cmd_we),
      .cmd_addr_r(cv_cmd_addr),
      .cmd_len_r(cv_cmd_len),
      .cmd_ready(cv_cmd_ready),
      .rvalid(cv_rvalid),
      .rdata(cv_rdata),
      .wvalid_r(cv_wvalid),
      .wdata_r(cv_wdata),
      .wready(cv_wready),
      .abort(cv_abort),
      .cnv_valid(cnv_valid),
      .cnv_data(cnv_data),
      .cnv_ready_r(cnv_ready),
      .dac_valid_r(),
      .dac_data_r(),
      .dac_ready(1'b0)
   );

   // output channel: fifo filled from host, drained to the dac
   sgd_chan #(.TO_HOST(0)) u_ou (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .en(en_r[1]),
      .soft_rst(srst_r[1]),
      .first_ptr(first_ou_r),
      .unhold(unhold_r[1]),
      .cur_ptr_r(cur_ou),
      .lvl_r(lvl_ou),
      .idle_r(idle[1]),
      .done_r(done[1]),
      .err_r(err[1]),
      .count_r(cnt_ou),
      .desc_evt_r(ou_desc_evt),
      .cmd_valid_r(ou_cmd_valid),
      .cmd_we_r(ou_cmd_we),
      .cmd_addr_r(ou_cmd_addr),
      .cmd_len_r(ou_cmd_len),
      .cmd_ready(ou_cmd_ready),
      .rvalid(ou_rvalid),
      .rdata(ou_rdata),
      .wvalid_r(ou_wvalid),
      .wdata_r(ou_wdata),
      .wready(ou_wready),
      .abort(ou_abort),
      .cnv_valid(1'b0),
      .cnv_data(32'h0000_0000),
      .cnv_ready_r(),
      .dac_valid_r(dac_valid),
      .dac_data_r(dac_data),
      .dac_ready(dac_ready)
   );

endmodule // sgd_dma

// File: hdl/sgd_regs.vh
// Purpose: constants for the scatter/gather dma engine
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   included by sgd_dma.v only
//
// Functional notes
// RULE_01: current descriptor pointer readable per channel.
// RULE_02: after master abort the pointer keeps the culprit.
// RULE_03: pointer write while halted refetches and resumes.
// RULE_04: output fifo words, read only, upper half-word.
// RULE_05: input fifo words, read only, low bits; gap reserved.
// RULE_06: software treats fill levels as approximate.
// RULE_07: bursts of sixteen words whenever possible.
// RULE_08: converter channel writes host, output channel reads it.
// RULE_09: fifos hide bus latency from the converters.
// RULE_10: descriptor holds size, control, buffer, next pointer.
// RULE_11: descriptors and buffers anywhere in 32-bit space.
// RULE_12: start fetches from the first pointer.
// RULE_13: after a descriptor: end of list halts, else next.
// RULE_14: status word written into each served descriptor.
// RULE_15: descriptor completion can raise an event.
// RULE_16: software builds chain, sets first pointer, then enables.
// RULE_17: null end-of-list descriptor halts without data.
// RULE_18: a chain appended in time is simply followed.
// RULE_19: software relinks the old tail, then unholds.
// RULE_20: single size-plus-end descriptor halts; unhold repeats it.
// RULE_21: enable starts at first descriptor; clear suspends, set resumes.
// RULE_22: word 0 bit 0 is end of list; serving it sets done.
// RULE_23: the value written to the pointer register is ignored.
// RULE_24: the pointer follows the next address on each branch.
`ifndef SGD_REGS_VH
`define SGD_REGS_VH

// ****************
// register offsets
// ****************
`define SGD_CSR_CNV 8'h00
`define SGD_FIRST_CNV 8'h04
`define SGD_CUR_CNV 8'h08
`define SGD_CSR_OUT 8'h0C
`define SGD_FIRST_OUT 8'h10
`define SGD_CUR_OUT 8'h14
`define SGD_FILL 8'h18

// ****************
// control / status fields
// ****************
`define SGD_CSR_EN 0
`define SGD_CSR_RST 1
`define SGD_CSR_IDLE 8
`define SGD_CSR_DONE 9
`define SGD_CSR_ERR 10
`define SGD_PTR_RESET 32'h0000_0000

// ****************
// descriptor layout
// ****************
`define SGD_DESC_WORDS 5'h03
`define SGD_DESC_STAT_OFS 32'h0000_000C
`define SGD_D0_LIST_END 0
`define SGD_D0_IRQ 1

// ****************
// fifo and bus
// ****************
`define SGD_FIFO_AW 8
`define SGD_FIFO_DEPTH 9'h100
`define SGD_FIFO_HIWAT 9'h0FE
`define SGD_BURST 16'h0010

`endif

// File: sim/sgd_dma_props.sv
// Purpose: port-level checks on the dma engine
// Assumes: one clock domain
// Notes:   bound into sgd_dma
`timescale 1ns/10ps
module sgd_dma_chk (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // register port
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire [31:0] reg_rdata_r,
   // memory masters
   input wire ou_cmd_valid,
   input wire ou_cmd_we,
   input wire [31:0] ou_cmd_addr,
   input wire [4:0] ou_cmd_len,
   input wire ou_cmd_ready,
   input wire ou_wvalid,
   input wire [31:0] ou_wdata,
   input wire ou_wready,
   input wire ou_abort,
   input wire cv_cmd_valid,
   input wire [4:0] cv_cmd_len
);
// ******************************
// properties
// ******************************
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (!rst_n);
AST_RDATA_IDLE:
   assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
   else $error("read data not zero");
AST_FILL_RSV:
   assert property ($past(reg_rd) && $past(reg_addr) == 8'h18 |->
      reg_rdata_r[31:25] == 7'h00 && reg_rdata_r[15:9] == 7'h00)
   else $error("fill level reserved bits set");
AST_CMD_HOLD:
   assert property (ou_cmd_valid && !ou_cmd_ready && !ou_abort |=>
      ou_cmd_valid && $stable(ou_cmd_addr))
   else $error("command dropped before ready");
AST_OU_LEN:
   assert property (ou_cmd_valid |-> ou_cmd_len inside {[1:16]})
   else $error("bad output burst length");
AST_CV_LEN:
   assert property (cv_cmd_valid |-> cv_cmd_len inside {[1:16]})
   else $error("bad converter burst length");
AST_STAT_LEN:
   assert property (ou_cmd_valid && ou_cmd_we |-> ou_cmd_len == 5'h01)
   else $error("status write not a single word");
AST_ALIGN:
   assert property (ou_cmd_valid |-> ou_cmd_addr[1:0] == 2'h0)
   else $error("unaligned host address");
AST_WV_DROP:
   assert property (ou_wvalid && ou_wready |=> !ou_wvalid)
   else $error("write valid held after take");
AST_WV_DONE:
   assert property (ou_wvalid |-> ou_wdata[0])
   else $error("status word without done bit");
// main scenarios reached
cover property (ou_wvalid && ou_wready);
cover property (cv_cmd_valid && cv_cmd_len == 5'h05);
cover property ($past(reg_rd) && $past(reg_addr) == 8'h14);
endmodule // sgd_dma_chk

bind sgd_dma sgd_dma_chk i_sgd_dma_chk (.*);

// File: sim/sgd_host_mem.sv
// Purpose: host memory answering one dma memory master
// Assumes: 1 KB, addresses wrap
// Notes:   SLOW takes commands every other cycle
`timescale 1ns/10ps
module sgd_host_mem #(
   parameter SLOW = 0
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // command
   input wire cmd_valid,
   input wire cmd_we,
   input wire [31:0] cmd_addr,
   input wire [4:0] cmd_len,
   output reg cmd_ready,
   // data
   output reg rvalid,
   output reg [31:0] rdata,
   input wire wvalid,
   input wire [31:0] wdata,
   output reg wready
);
reg [31:0] mem [0:255];
reg [31:0] a_r;
reg [4:0] n_r;
reg rd_r;
reg tick_r;
// ******************************
// burst engine
// ******************************
// idle read data flips so a stale word never looks valid
always @(posedge ref_clk or negedge rst_n)
   if (!rst_n)
   begin
      cmd_ready <= 1'b0;
      rvalid <= 1'b0;
      wready <= 1'b0;
      rdata <= 32'h0;
      n_r <= 5'h00;
      tick_r <= 1'b0;
   end
   else
   begin
      cmd_ready <= 1'b0;
      rvalid <= 1'b0;
      wready <= 1'b0;
      rdata <= ~rdata;
      tick_r <= ~tick_r;
      if (cmd_valid && cmd_ready)
      begin
         a_r <= cmd_addr;
         n_r <= cmd_len;
         rd_r <= !cmd_we;
      end
      else if (n_r != 5'h00 && rd_r)
      begin
         rvalid <= 1'b1;
         rdata <= mem[a_r[9:2]];
         a_r <= a_r + 32'h4;
         n_r <= n_r - 5'h01;
      end
      else if (n_r != 5'h00 && wvalid && !wready)
      begin
         wready <= 1'b1;
         mem[a_r[9:2]] <= wdata;
         a_r <= a_r + 32'h4;
         n_r <= n_r - 5'h01;
      end
      else if (cmd_valid && n_r == 5'h00 && (SLOW == 0 || tick_r))
         cmd_ready <= 1'b1;
   end
endmodule // sgd_host_mem

// File: sim/tb.sv
// Purpose: self-checking bench for the two-channel dma engine
// Assumes: 16-byte aligned descriptors, 1 KB memories
// Notes:   output side memory is slow, converter side prompt
`timescale 1ns/10ps
module tb;
reg ref_clk = 1'b0;
reg rst_n = 1'b0;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg [7:0] reg_addr = 8'h00;
reg [31:0] reg_wdata = 32'h0;
reg cnv_valid = 1'b0;
reg [31:0] cnv_data = 32'h0;
reg dac_ready = 1'b0;
reg cv_abort = 1'b0;
reg ou_abort = 1'b0;
wire [31:0] reg_rdata_r, cv_cmd_addr, cv_rdata, cv_wdata;
wire [31:0] ou_cmd_addr, ou_rdata, ou_wdata, dac_data;
wire [4:0] cv_cmd_len, ou_cmd_len;
wire cv_cmd_valid, cv_cmd_we, cv_cmd_ready, cv_rvalid, cv_wvalid;
wire ou_cmd_valid, ou_cmd_we, ou_cmd_ready, ou_rvalid, ou_wvalid;
wire cv_wready, ou_wready, cnv_ready, dac_valid, cv_desc_evt, ou_desc_evt;
reg [31:0] v;
reg [31:0] dq [$];
integer n_mismatch = 0, checked = 0, cyc = 0, ou_n = 0, cv_n = 0, i;
always #12.5 ref_clk = ~ref_clk;
sgd_dma i_sgd_dma (.*);
sgd_host_mem i_sgd_host_mem (.ref_clk(ref_clk), .rst_n(rst_n),
   .cmd_valid(cv_cmd_valid), .cmd_we(cv_cmd_we), .cmd_addr(cv_cmd_addr),
   .cmd_len(cv_cmd_len), .cmd_ready(cv_cmd_ready), .rvalid(cv_rvalid),
   .rdata(cv_rdata), .wvalid(cv_wvalid), .wdata(cv_wdata),
   .wready(cv_wready));
sgd_host_mem #(.SLOW(1)) i_sgd_host_mem_ou (.ref_clk(ref_clk),
   .rst_n(rst_n), .cmd_valid(ou_cmd_valid), .cmd_we(ou_cmd_we),
   .cmd_addr(ou_cmd_addr), .cmd_len(ou_cmd_len), .cmd_ready(ou_cmd_ready),
   .rvalid(ou_rvalid), .rdata(ou_rdata), .wvalid(ou_wvalid),
   .wdata(ou_wdata), .wready(ou_wready));
// ******************************
// tasks
// ******************************
task close_out;
   begin
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
endtask
task chk(input string nm, input [31:0] s, input [31:0] e);
   begin
      checked = checked + 1;
      if (s !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("BAD %s exp=%h got=%h", nm, e, s);
      end
   end
endtask
// gap cycle: no strobe is set twice in one step
task wr(input [7:0] a, input [31:0] d);
   begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   end
endtask
task rd(input [7:0] a);
   begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      v = reg_rdata_r;
   end
endtask
task wt(input integer k);
   begin
      for (i = 0; i < 3000 && ou_n + cv_n < k; i = i + 1)
         @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
   end
endtask
// event counting, dac capture and hang guard
always @(posedge ref_clk)
begin
   cyc <= cyc + 1;
   if (ou_desc_evt)
      ou_n <= ou_n + 1;
   if (cv_desc_evt)
      cv_n <= cv_n + 1;
   if (dac_valid && dac_ready)
      dq.push_back(dac_data);
   if (cyc == 20000)
   begin
      n_mismatch = n_mismatch + 1;
      close_out;
   end
end
// ******************************
// scenarios
// ******************************
initial
begin
   repeat (12) @(posedge ref_clk);
   rst_n <= 1'b1;
   @(posedge ref_clk);
   rd(8'h0C); chk("ou_csr", v, 32'h0000_0100);
   rd(8'h14); chk("ou_cur", v, 32'h0);
   rd(8'h18); chk("fill", v, 32'h0);
   rd(8'h1C); chk("unmapped", v, 32'h0);
   // two-descriptor chain ending in a null descriptor
   i_sgd_host_mem_ou.mem[0] = 32'h0002_0002;
   i_sgd_host_mem_ou.mem[1] = 32'h100;
   i_sgd_host_mem_ou.mem[2] = 32'h40;
   i_sgd_host_mem_ou.mem[16] = 32'h0000_0003;
   i_sgd_host_mem_ou.mem[64] = 32'h11;
   i_sgd_host_mem_ou.mem[65] = 32'h22;
   wr(8'h10, 32'h0);
   wr(8'h0C, 32'h1);
   wt(2);
   rd(8'h18); chk("fill_ou", v, 32'h10000);
   dac_ready <= 1'b1;
   chk("st0", i_sgd_host_mem_ou.mem[3], 32'h20001);
   chk("st1", i_sgd_host_mem_ou.mem[19], 32'h1);
   rd(8'h14); chk("cur", v, 32'h40);
   rd(8'h0C); chk("done", v & 32'h601, 32'h201);
   chk("dq0", dq[0], 32'h11);
   chk("dq1", dq[1], 32'h22);
   // relink the null descriptor with data, then unhold
   i_sgd_host_mem_ou.mem[16] = 32'h0001_0003;
   i_sgd_host_mem_ou.mem[17] = 32'h180;
   i_sgd_host_mem_ou.mem[19] = 32'h0;
   i_sgd_host_mem_ou.mem[96] = 32'h33;
   wr(8'h14, 32'hDEAD_BEEF);
   wt(3);
   chk("st2", i_sgd_host_mem_ou.mem[19], 32'h0001_0001);
   chk("dq2", dq[2], 32'h33);
   chk("dqn", 32'(dq.size()), 32'h3);
   chk("ou_evt", 32'(ou_n), 32'h3);
   rd(8'h14); chk("cur_kept", v, 32'h40);
   // converter channel: five samples, one short burst
   i_sgd_host_mem.mem[0] = 32'h0005_0003;
   i_sgd_host_mem.mem[1] = 32'h100;
   i_sgd_host_mem.mem[2] = 32'h0;
   wr(8'h04, 32'h0);
   wr(8'h00, 32'h1);
   for (i = 0; i < 5; i = i + 1)
   begin
      cnv_valid <= 1'b1;
      cnv_data <= 32'hA0 + i;
      @(posedge ref_clk);
      while (!cnv_ready)
         @(posedge ref_clk);
   end
   cnv_valid <= 1'b0;
   wt(4);
   for (i = 0; i < 5; i = i + 1)
      chk("cv_buf", i_sgd_host_mem.mem[64 + i], 32'hA0 + i);
   chk("cv_st", i_sgd_host_mem.mem[3], 32'h50001);
   chk("cv_evt", cv_n, 32'h1);
   rd(8'h18); chk("fill_end", v, 32'h0);
   // master abort on the first fetch of a new list
   wr(8'h0C, 32'h2);
   wr(8'h10, 32'h80);
   wr(8'h0C, 32'h1);
   for (i = 0; i < 50 && !ou_cmd_valid; i = i + 1)
      @(posedge ref_clk);
   ou_abort <= 1'b1;
   @(posedge ref_clk);
   ou_abort <= 1'b0;
   repeat (4) @(posedge ref_clk);
   rd(8'h0C); chk("err", v & 32'h400, 32'h400);
   rd(8'h14); chk("cur_abort", v, 32'h80);
   rd(8'h10); chk("first", v, 32'h80);
   close_out;
end
endmodule // tb
